// File: hw/aso_ctrl.sv
`timescale 1ns/1ps
module aso_ctrl
  import aso_pkg::*;
#(
  parameter int CAL_CYCLES = 1024
) (
  input wire logic sysClk,
  input wire logic srst,
  input wire aso_axi_req_s axiReq,
  output aso_axi_rsp_s axiRsp,
  input wire logic calStrobe,
  input wire logic chipSelN,
  input wire logic sclkIn,
  output logic sclkOut,
  output logic sclkOe,
  output logic serialOutLine,
  output logic serialOe,
  output logic resultValidN,
  input wire logic [15:0] resultData,
  input wire logic resultLoad,
  output logic convRun,
  output logic bipolarMode,
  output logic calStart,
  output logic [1:0] calKind,
  output logic timingRestart,
  output logic irq
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic awHeld; logic wHeld; logic [7:0] awAddr; logic [31:0] wData; logic [3:0] wStrb;
    logic awReady; logic wReady; logic bValid; logic [1:0] bResp;
    logic arReady; logic rValid; logic [31:0] rData; logic [1:0] rResp;
    logic [CT_W-1:0] ctrl; logic [EV_W-1:0] stat; logic [EV_W-1:0] mask; logic irq;
    logic [2:0] calSy; logic [2:0] csSy; logic [2:0] ckSy;
    logic calLvl; logic csLvl; logic ckLvl;
    aso_cal_e calSt; logic [2:0] calCnt; logic [1:0] calKind; logic [15:0] calTimer;
    logic calStart; logic restart;
    logic [2:0] blankCnt; logic valid; logic [15:0] word;
    aso_ser_e serSt; logic [21:0] frame; logic [4:0] bitsLeft; logic [1:0] div;
    logic sclkOut; logic sclkOe; logic sdo; logic sdoOe; logic rdyN; logic convRun; logic bipolar;
  } aso_st_s;

  aso_st_s s_ff;
  aso_st_s nxt_s;
  logic [15:0] wordLsbFirst;

  // Each byte of the result mirrored, so a character frame shifts out LSB first
  for (genvar i = 0; i < 8; i++) begin : gRev
    assign wordLsbFirst[i] = s_ff.word[7 - i];
    assign wordLsbFirst[8 + i] = s_ff.word[15 - i];
  end

  // Outputs straight from the state register
  assign axiRsp = '{awready: s_ff.awReady, wready: s_ff.wReady, bvalid: s_ff.bValid, bresp: s_ff.bResp,
                    arready: s_ff.arReady, rvalid: s_ff.rValid, rdata: s_ff.rData, rresp: s_ff.rResp};
  assign sclkOut = s_ff.sclkOut;
  assign sclkOe = s_ff.sclkOe;
  assign serialOutLine = s_ff.sdo;
  assign serialOe = s_ff.sdoOe;
  assign resultValidN = s_ff.rdyN;
  assign convRun = s_ff.convRun;
  assign bipolarMode = s_ff.bipolar;
  assign calStart = s_ff.calStart;
  assign calKind = s_ff.calKind;
  assign timingRestart = s_ff.restart;
  assign irq = s_ff.irq;

  // Read data for a register address; unmapped reads answer with zero
  function automatic logic [31:0] rdMux(input aso_st_s st, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      ADDR_CTRL: d = 32'(st.ctrl);
      ADDR_STAT: d = 32'(st.stat);
      ADDR_MASK: d = 32'(st.mask);
      ADDR_STATE: d = 32'({st.calKind, st.calSt == CL_RUN, st.serSt != SR_IDLE, st.rdyN, st.valid});
      ADDR_DATA: d = 32'(st.word);
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == ADDR_CTRL || a == ADDR_STAT || a == ADDR_MASK || a == ADDR_STATE || a == ADDR_DATA;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic calRise;
    logic ckFall;
    logic held;
    logic step;
    logic [1:0] mode;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] clr;
    calRise = 1'b0;
    ckFall = 1'b0;
    held = 1'b0;
    step = 1'b0;
    ev = '0;
    clr = '0;
    nxt_s = s_ff;
    mode = s_ff.ctrl[CT_MODE +: 2];
    nxt_s.calStart = 1'b0;
    nxt_s.restart = 1'b0;

    // Pin synchronisers; a level counts once the second and third stages agree
    nxt_s.calSy = {s_ff.calSy[1:0], calStrobe};
    nxt_s.csSy = {s_ff.csSy[1:0], chipSelN};
    nxt_s.ckSy = {s_ff.ckSy[1:0], sclkIn};
    if (s_ff.calSy[2] == s_ff.calSy[1]) begin
      nxt_s.calLvl = s_ff.calSy[2];
    end
    if (s_ff.csSy[2] == s_ff.csSy[1]) begin
      nxt_s.csLvl = s_ff.csSy[2];
    end
    if (s_ff.ckSy[2] == s_ff.ckSy[1]) begin
      nxt_s.ckLvl = s_ff.ckSy[2];
    end
    calRise = nxt_s.calLvl && !s_ff.calLvl;
    ckFall = s_ff.ckLvl && !nxt_s.ckLvl;

    // Calibration strobe: qualify length, then run calibration after it drops
    unique case (s_ff.calSt)
      CL_IDLE, CL_RUN: begin
        if (s_ff.calSt == CL_RUN) begin
          nxt_s.calTimer = s_ff.calTimer - 16'h0001;
          if (s_ff.calTimer == 16'h0001) begin
            nxt_s.calSt = CL_IDLE;
            ev[EV_CAL] = 1'b1;
          end
        end
        if (calRise) begin
          nxt_s.calSt = CL_HIGH;
          nxt_s.calCnt = 3'h1;
          nxt_s.calKind = {s_ff.ctrl[CT_CAL_B], s_ff.ctrl[CT_CAL_A]};
        end
      end
      CL_HIGH: begin
        if (nxt_s.calLvl) begin
          if (s_ff.calCnt <= CAL_QUAL_CYC) begin
            nxt_s.calCnt = s_ff.calCnt + 3'h1;
          end
          if (s_ff.calCnt == CAL_QUAL_CYC) begin
            nxt_s.restart = 1'b1;
          end
        end else if (s_ff.calCnt > CAL_QUAL_CYC) begin
          nxt_s.calSt = CL_RUN;
          nxt_s.calStart = 1'b1;
          nxt_s.calTimer = 16'(CAL_CYCLES);
        end else begin
          nxt_s.calSt = CL_IDLE;
        end
      end
    endcase
    // Internal reset holds while a qualified strobe stays high
    held = nxt_s.calSt == CL_HIGH && nxt_s.calCnt > CAL_QUAL_CYC;

    // Conversion control: sleep and calibration both suspend conversion
    nxt_s.convRun = s_ff.ctrl[CT_SLEEP_N] && !held && nxt_s.calSt != CL_RUN;
    nxt_s.bipolar = s_ff.ctrl[CT_BIPOLAR];

    // New result: blank data ready, then mark valid
    if (s_ff.blankCnt != 3'h0) begin
      nxt_s.blankCnt = s_ff.blankCnt - 3'h1;
      if (s_ff.blankCnt == 3'h1) begin
        nxt_s.valid = 1'b1;
        ev[EV_NEW] = 1'b1;
      end
    end
    if (resultLoad && s_ff.convRun) begin
      nxt_s.blankCnt = BLANK_CYC;
      nxt_s.valid = 1'b0;
      nxt_s.word = resultData;
    end

    // Serial clock direction follows the mode
    nxt_s.sclkOe = mode == MODE_SELF_CLOCKED_SYNC;
    nxt_s.sclkOut = 1'b0;

    // Serial shifter
    unique case (s_ff.serSt)
      SR_IDLE: begin
        if (!s_ff.csLvl && s_ff.valid && s_ff.blankCnt == 3'h0) begin
          nxt_s.serSt = SR_SHIFT;
          nxt_s.sdoOe = 1'b1;
          nxt_s.div = 2'h0;
          if (mode == MODE_ASYNC_CHAR) begin
            // Each byte LSB first between a low start bit and two high stop bits
            nxt_s.frame = {1'b0, wordLsbFirst[15:8], 2'b11, 1'b0, wordLsbFirst[7:0], 2'b11};
            nxt_s.bitsLeft = CHAR_FRAME_BITS;
          end else begin
            nxt_s.frame = {s_ff.word, 6'h00};
            nxt_s.bitsLeft = WORD_BITS;
          end
        end
      end
      SR_SHIFT: begin
        if (mode == MODE_SELF_CLOCKED_SYNC) begin
          // Low for three cycles, high for one; data moves on the falling edge
          nxt_s.div = s_ff.div + 2'h1;
          nxt_s.sclkOut = nxt_s.div > (SCLK_DIV_M1 - SCLK_HI_CYC);
          step = s_ff.div == SCLK_DIV_M1;
        end else begin
          step = ckFall;
        end
        if (s_ff.csLvl) begin
          // Chip select withdrawn mid-word: abandon it, the result stays valid
          nxt_s.serSt = SR_IDLE;
          nxt_s.sdoOe = 1'b0;
          nxt_s.sclkOut = 1'b0;
        end else if (step) begin
          if (s_ff.bitsLeft == 5'h01) begin
            nxt_s.serSt = SR_HOLD;
            nxt_s.sdoOe = 1'b0;
            nxt_s.sclkOut = 1'b0;
            if (s_ff.blankCnt == 3'h0) begin
              nxt_s.valid = 1'b0;
            end
            ev[EV_WORD] = 1'b1;
          end else begin
            nxt_s.frame = {s_ff.frame[20:0], 1'b0};
            nxt_s.bitsLeft = s_ff.bitsLeft - 5'h01;
          end
        end
      end
      SR_HOLD: begin
        // One word per chip select assertion
        if (s_ff.csLvl) begin
          nxt_s.serSt = SR_IDLE;
        end
      end
    endcase
    if (held) begin
      nxt_s.serSt = SR_IDLE;
      nxt_s.valid = 1'b0;
      nxt_s.blankCnt = 3'h0;
      nxt_s.sdoOe = 1'b0;
      nxt_s.sclkOut = 1'b0;
    end
    nxt_s.sdo = nxt_s.frame[21];
    nxt_s.rdyN = !nxt_s.valid || nxt_s.blankCnt != 3'h0;

    // AXI4-Lite write: address and data in either order, response after both
    if (axiReq.awvalid && s_ff.awReady) begin
      nxt_s.awHeld = 1'b1;
      nxt_s.awAddr = axiReq.awaddr[7:0];
    end
    if (axiReq.wvalid && s_ff.wReady) begin
      nxt_s.wHeld = 1'b1;
      nxt_s.wData = axiReq.wdata;
      nxt_s.wStrb = axiReq.wstrb;
    end
    if (s_ff.bValid && axiReq.bready) begin
      nxt_s.bValid = 1'b0;
    end
    if (s_ff.awHeld && s_ff.wHeld && !s_ff.bValid) begin
      nxt_s.awHeld = 1'b0;
      nxt_s.wHeld = 1'b0;
      nxt_s.bValid = 1'b1;
      nxt_s.bResp = mapped(s_ff.awAddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_ff.wStrb[0]) begin
        unique case (s_ff.awAddr)
          ADDR_CTRL: nxt_s.ctrl = s_ff.wData[CT_W-1:0];
          ADDR_STAT: clr = s_ff.wData[EV_W-1:0];
          ADDR_MASK: nxt_s.mask = s_ff.wData[EV_W-1:0];
          default: nxt_s.ctrl = nxt_s.ctrl;
        endcase
      end
    end
    nxt_s.awReady = !nxt_s.awHeld && !nxt_s.bValid;
    nxt_s.wReady = !nxt_s.wHeld && !nxt_s.bValid;

    // AXI4-Lite read: one cycle from address to data
    if (s_ff.rValid && axiReq.rready) begin
      nxt_s.rValid = 1'b0;
    end
    if (axiReq.arvalid && s_ff.arReady) begin
      nxt_s.rValid = 1'b1;
      nxt_s.rData = rdMux(s_ff, axiReq.araddr[7:0]);
      nxt_s.rResp = mapped(axiReq.araddr[7:0]) ? RESP_OKAY : RESP_SLVERR;
    end
    nxt_s.arReady = !nxt_s.rValid;

    // Sticky events; a new event wins over a same-cycle clear
    nxt_s.stat = (s_ff.stat & ~clr) | ev;
    nxt_s.irq = |(nxt_s.stat & nxt_s.mask);

    if (srst) begin
      nxt_s = '0;
      nxt_s.ctrl = CTRL_RST;
      nxt_s.calSt = CL_IDLE;
      nxt_s.serSt = SR_IDLE;
      nxt_s.calSy = 3'h0;
      nxt_s.csSy = 3'h7;
      nxt_s.ckSy = 3'h0;
      nxt_s.csLvl = 1'b1;
      nxt_s.rdyN = 1'b1;
    end
  end

  // Single state register
  always_ff @(posedge sysClk) begin
    s_ff <= nxt_s;
  end

endmodule

// File: include/aso_pkg.sv
package aso_pkg;
  // ****************************************
  // Register map, AXI4-Lite byte addresses
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0C;
  localparam logic [7:0] ADDR_DATA = 8'h10;
  // Control fields
  localparam int CT_MODE = 0;
  localparam int CT_SLEEP_N = 2;
  localparam int CT_BIPOLAR = 3;
  localparam int CT_CAL_A = 4;
  localparam int CT_CAL_B = 5;
  localparam int CT_W = 6;
  localparam logic [5:0] CTRL_RST = 6'h05;
  // Interface modes
  localparam logic [1:0] MODE_ASYNC_CHAR = 2'h0;
  localparam logic [1:0] MODE_EXT_CLOCKED_SYNC = 2'h1;
  localparam logic [1:0] MODE_SELF_CLOCKED_SYNC = 2'h2;
  // Event bits of status and mask
  localparam int EV_CAL = 0;
  localparam int EV_WORD = 1;
  localparam int EV_NEW = 2;
  localparam int EV_W = 3;
  // ****************************************
  // Timing counts in master clock cycles, clock duty in percent, frame lengths in bits, response codes
  // ****************************************
  localparam logic [2:0] CAL_QUAL_CYC = 3'h4;
  localparam logic [2:0] BLANK_CYC = 3'h4;
  localparam logic [1:0] SCLK_DIV_M1 = 2'h3;
  localparam int SCLK_DUTY_PCT = 25;
  localparam logic [1:0] SCLK_HI_CYC = 2'((int'(SCLK_DIV_M1) + 1) * SCLK_DUTY_PCT / 100);
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [4:0] CHAR_FRAME_BITS = 5'h16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {SR_IDLE = 3'b001, SR_SHIFT = 3'b010, SR_HOLD = 3'b100} aso_ser_e;
  typedef enum logic [2:0] {CL_IDLE = 3'b001, CL_HIGH = 3'b010, CL_RUN = 3'b100} aso_cal_e;
  typedef struct packed {
    logic awvalid; logic [31:0] awaddr; logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
    logic bready; logic arvalid; logic [31:0] araddr; logic rready;
  } aso_axi_req_s;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } aso_axi_rsp_s;
endpackage

// File: verif/adc_serial_output_control_bench.sv
`timescale 1ns/1ps
module adc_serial_output_control_bench;
  import aso_pkg::*;
  logic sysClk = 1'b0;
  logic srst = 1'b1;
  logic calStrobe = 1'b0;
  logic resultLoad = 1'b0;
  logic [15:0] resultData = 16'h0000;
  aso_axi_req_s axiReq = '0;
  aso_axi_rsp_s axiRsp;
  logic chipSelN, sclkIn, sclkOut, sclkOe, serialOutLine, serialOe, resultValidN;
  logic convRun, bipolarMode, calStart, timingRestart, irq;
  logic [1:0] calKind;
  logic [1:0] wrResp;
  int errors = 0;
  int cmpCount = 0;
  initial begin
    forever #50 sysClk = ~sysClk;
  end
  // Short calibration keeps the run brief
  aso_ctrl #(.CAL_CYCLES(16)) aso_ctrl_inst (.sysClk(sysClk), .srst(srst), .axiReq(axiReq), .axiRsp(axiRsp),
    .calStrobe(calStrobe), .chipSelN(chipSelN), .sclkIn(sclkIn), .sclkOut(sclkOut), .sclkOe(sclkOe),
    .serialOutLine(serialOutLine), .serialOe(serialOe), .resultValidN(resultValidN), .resultData(resultData),
    .resultLoad(resultLoad), .convRun(convRun), .bipolarMode(bipolarMode), .calStart(calStart),
    .calKind(calKind), .timingRestart(timingRestart), .irq(irq));
  aso_host_model aso_host_model_inst (.sysClk(sysClk), .sclkOut(sclkOut), .serialOutLine(serialOutLine),
    .chipSelN(chipSelN), .sclkIn(sclkIn));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmpCount, errors);
    if (errors == 0 && cmpCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmpCount++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic timeout_if(input bit bad);
    if (bad) begin
      chk("wait bound", 32'h0, 32'h1);
      end_of_test();
    end
  endtask
  task automatic wait_pulse(input bit cal);
    int t;
    for (t = 0; t < 40 && (cal ? calStart : timingRestart) !== 1'b1; t++) @(posedge sysClk);
    timeout_if(t >= 40);
  endtask
  // Each channel is dropped at the edge that takes it
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge sysClk);
    axiReq.awaddr <= 32'(a);
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hf;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    axiReq.bready <= 1'b1;
    do begin
      @(posedge sysClk);
      t++;
      if (axiRsp.awready === 1'b1) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready === 1'b1) axiReq.wvalid <= 1'b0;
    end while (axiRsp.bvalid !== 1'b1 && t < 50);
    wrResp = axiRsp.bresp;
    axiReq.bready <= 1'b0;
    timeout_if(t >= 50);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    @(posedge sysClk);
    axiReq.araddr <= 32'(a);
    axiReq.arvalid <= 1'b1;
    axiReq.rready <= 1'b1;
    do begin
      @(posedge sysClk);
      t++;
      if (axiRsp.arready === 1'b1) axiReq.arvalid <= 1'b0;
    end while (axiRsp.rvalid !== 1'b1 && t < 50);
    d = axiRsp.rdata;
    r = axiRsp.rresp;
    axiReq.rready <= 1'b0;
    timeout_if(t >= 50);
  endtask
  task automatic load(input logic [15:0] v);
    @(posedge sysClk);
    resultData <= v;
    resultLoad <= 1'b1;
    @(posedge sysClk);
    resultLoad <= 1'b0;
  endtask
  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++) rev8[i] = b[7 - i];
  endfunction
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic s_reset();
    logic [31:0] d;
    logic [1:0] r;
    chk("resultValidN", 32'h1, 32'(resultValidN));
    axi_wr(8'h20, 32'h0000_003f);
    chk("unmapped wr resp", 32'(RESP_SLVERR), 32'(wrResp));
    axi_rd(ADDR_CTRL, d, r);
    chk("CTRL", 32'(CTRL_RST), d);
    axi_rd(8'h20, d, r);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
    chk("unmapped data", 32'h0, d);
  endtask
  task automatic s_irq();
    logic [31:0] d;
    logic [1:0] r;
    load(16'ha5c3);
    @(posedge sysClk);
    chk("blanking", 32'h1, 32'(resultValidN));
    repeat (4) @(posedge sysClk);
    chk("ready", 32'h0, 32'(resultValidN));
    axi_rd(ADDR_STAT, d, r);
    chk("STAT new", 32'h4, d & 32'h4);
    chk("irq masked", 32'h0, 32'(irq));
    axi_wr(ADDR_MASK, 32'h4);
    chk("mask wr resp", 32'(RESP_OKAY), 32'(wrResp));
    repeat (2) @(posedge sysClk);
    chk("irq on", 32'h1, 32'(irq));
    axi_wr(ADDR_STAT, 32'h4);
    repeat (2) @(posedge sysClk);
    chk("irq cleared", 32'h0, 32'(irq));
  endtask
  // Async frames reach the host LSB first per byte, so the expected bits are mirrored
  task automatic s_word(input logic [1:0] mode, input logic [15:0] v);
    logic [21:0] cap;
    logic [21:0] exp;
    bit ok;
    bit sc;
    sc = (mode == MODE_SELF_CLOCKED_SYNC);
    axi_wr(ADDR_CTRL, 32'h4 | 32'(mode));
    repeat (2) @(posedge sysClk);
    chk("sclkOe", 32'(sc), 32'(sclkOe));
    load(v);
    repeat (8) @(posedge sysClk);
    aso_host_model_inst.fetch(mode == MODE_ASYNC_CHAR ? 22 : 16, sc, cap, ok);
    exp = (mode == MODE_ASYNC_CHAR) ? {1'b0, rev8(v[15:8]), 2'b11, 1'b0, rev8(v[7:0]), 2'b11} : 22'(v);
    chk("word", 32'(exp), 32'(cap));
    chk("clock pulses", 32'h1, 32'(ok));
    timeout_if(!ok);
    chk("ready after word", 32'h1, 32'(resultValidN));
  endtask
  task automatic s_cal();
    logic [31:0] d;
    logic [1:0] r;
    int n;
    axi_wr(ADDR_CTRL, 32'h1d);
    load(16'h1234);
    repeat (6) @(posedge sysClk);
    chk("bipolar", 32'h1, 32'(bipolarMode));
    calStrobe <= 1'b1;
    wait_pulse(1'b0);
    chk("calKind", 32'h1, 32'(calKind));
    repeat (2) @(posedge sysClk);
    chk("held", 32'h0, 32'(convRun));
    chk("valid cleared", 32'h1, 32'(resultValidN));
    calStrobe <= 1'b0;
    wait_pulse(1'b1);
    repeat (24) @(posedge sysClk);
    axi_rd(ADDR_STAT, d, r);
    chk("cal done", 32'h1, d & 32'h1);
    chk("running", 32'h1, 32'(convRun));
    calStrobe <= 1'b1;
    repeat (3) @(posedge sysClk);
    calStrobe <= 1'b0;
    n = 0;
    repeat (12) begin
      @(posedge sysClk);
      n += int'(timingRestart === 1'b1);
    end
    chk("short strobe", 32'h0, 32'(n));
  endtask
  task automatic s_sleep();
    axi_wr(ADDR_CTRL, 32'h1);
    repeat (2) @(posedge sysClk);
    chk("asleep", 32'h0, 32'(convRun));
    load(16'h5a5a);
    repeat (8) @(posedge sysClk);
    chk("load ignored", 32'h1, 32'(resultValidN));
  endtask
  initial begin
    repeat (12) @(posedge sysClk);
    srst <= 1'b0;
    repeat (4) @(posedge sysClk);
    s_reset();
    s_irq();
    s_word(MODE_EXT_CLOCKED_SYNC, 16'ha5c3);
    s_word(MODE_SELF_CLOCKED_SYNC, 16'h8001);
    s_word(MODE_ASYNC_CHAR, 16'h3cf0);
    s_cal();
    s_sleep();
    end_of_test();
  end
endmodule

// File: verif/aso_ctrl_asserts.sv
`timescale 1ns/1ps
module aso_ctrl_asserts
  import aso_pkg::*;
#(
  parameter int CAL_CYCLES = 1024
) (
  input wire logic sysClk,
  input wire logic srst,
  input wire logic calStrobe,
  input wire logic chipSelN,
  input wire logic sclkOut,
  input wire logic sclkOe,
  input wire logic serialOe,
  input wire logic resultValidN,
  input wire logic resultLoad,
  input wire logic convRun,
  input wire logic calStart,
  input wire logic timingRestart
);
  logic [3:0] hiRun;
  logic [3:0] lastRun;
  logic [4:0] pulseCnt;
  int calCnt;
  // ****************************************
  // Helper counters
  // ****************************************
  // Strobe run lengths saturate, so a stuck strobe never wraps into a short one
  always_ff @(posedge sysClk) begin
    if (srst) begin
      hiRun <= 4'h0;
      lastRun <= 4'h0;
      pulseCnt <= 5'h00;
      calCnt <= 0;
    end else begin
      hiRun <= calStrobe ? hiRun + {3'h0, hiRun != 4'hf} : 4'h0;
      lastRun <= (!calStrobe && hiRun != 4'h0) ? hiRun : lastRun;
      pulseCnt <= !serialOe ? 5'h00 : pulseCnt + {4'h0, sclkOut};
      calCnt <= calStart ? CAL_CYCLES - 2 : (calCnt != 0 ? calCnt - 1 : 0);
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge sysClk); endclocking
  default disable iff (srst);
  load_blank_a: assert property (resultLoad && convRun |=> resultValidN [*4] ##1 !resultValidN)
    else $error("data ready blanking not four cycles");
  sclk_duty_a: assert property ($rose(sclkOut) |=> !sclkOut [*3])
    else $error("serial clock duty wrong");
  sclk_gate_a: assert property (sclkOut |-> serialOe && sclkOe)
    else $error("serial clock outside a word");
  pulse_count_a: assert property ($fell(serialOe) && sclkOe && !chipSelN && !timingRestart |-> pulseCnt == 5'h10)
    else $error("word not sixteen clocks");
  restart_len_a: assert property (timingRestart |-> hiRun > 4'h4 || lastRun > 4'h4)
    else $error("restart after short strobe");
  cal_start_a: assert property (calStart |-> !calStrobe && lastRun > 4'h4)
    else $error("calibration start without strobe fall");
  hold_run_a: assert property (timingRestart |-> ##2 (!convRun && resultValidN))
    else $error("state not held after restart");
  cal_run_a: assert property (calCnt != 0 |-> !convRun)
    else $error("converting during calibration");
  word_done_a: assert property ($fell(serialOe) && !chipSelN |-> ##[0:1] resultValidN)
    else $error("data ready low after word");
  word_start_a: assert property ($rose(serialOe) |-> !chipSelN && !resultValidN)
    else $error("word started without request");
  cover property ($fell(serialOe) && sclkOe);
  cover property (timingRestart);
  cover property (calStart);
endmodule
bind aso_ctrl aso_ctrl_asserts #(.CAL_CYCLES(CAL_CYCLES)) aso_ctrl_asserts_inst (.sysClk(sysClk), .srst(srst),
  .calStrobe(calStrobe), .chipSelN(chipSelN), .sclkOut(sclkOut), .sclkOe(sclkOe), .serialOe(serialOe),
  .resultValidN(resultValidN), .resultLoad(resultLoad), .convRun(convRun), .calStart(calStart),
  .timingRestart(timingRestart));

// File: verif/aso_host_model.sv
`timescale 1ns/1ps
module aso_host_model (
  input wire logic sysClk,
  input wire logic sclkOut,
  input wire logic serialOutLine,
  output logic chipSelN,
  output logic sclkIn
);
  // Clock rests low outside frames; host clock period is eight master cycles
  initial begin
    chipSelN = 1'b1;
    sclkIn = 1'b0;
  end
  // ****************************************
  // One word per chip select low period
  // ****************************************
  task automatic fetch(input int nBits, input bit selfClk, output logic [21:0] cap, output bit ok);
    int t;
    cap = '0;
    ok = 1'b1;
    @(posedge sysClk);
    chipSelN <= 1'b0;
    // Self-clocked words start on their own, so watch the clock at once
    if (!selfClk) repeat (10) @(posedge sysClk);
    for (int b = 0; b < nBits; b++) begin
      if (selfClk) begin
        for (t = 0; t < 40 && sclkOut !== 1'b1; t++) @(posedge sysClk);
        ok &= (t < 40);
        cap = {cap[20:0], serialOutLine};
        @(posedge sysClk);
      end else begin
        sclkIn <= 1'b1;
        repeat (4) @(posedge sysClk);
        // Sample late in the high phase, well clear of the shift after the fall
        cap = {cap[20:0], serialOutLine};
        sclkIn <= 1'b0;
        repeat (4) @(posedge sysClk);
      end
    end
    repeat (8) @(posedge sysClk);
    chipSelN <= 1'b1;
    repeat (8) @(posedge sysClk);
  endtask
endmodule
